// ---- design/ppac_pkg.sv ----
// Package: register map, field positions and types of the modulator control
// Summary of operation
// - Clock B rate chosen by bits 6..4 of prescale select; serves channels 2,3,6,7.
// - Clock A rate chosen by bits 2..0 of prescale select; serves channels 0,1,4,5.
// - Clock B code n divides the bus clock by two to the n.
// - Clock A code n divides the bus clock by two to the n.
// - Prescaler code writes take effect at once, mid-pulse.
// - Alignment bit one gives center-aligned output, zero left-aligned.
// - Join bits 7..4 pair channels 6/7, 4/5, 2/3, 0/1 into 16 bits.
// - Even channel is the high byte, odd channel the low byte.
// - Joined waveform appears only on the odd channel's output.
// - Joined pair takes clock, polarity, enable and alignment from the odd channel.
// - Stop-in-wait bit gates prescaler input while the processor waits.
// - Stop-in-freeze bit gates prescaler input during debug freeze.
// - Frozen counters hold and resume from held values.
// - Registers stay accessible while freeze gates the prescaler.
// - Select, alignment and control registers accessible in every mode.
// - Per-channel select bit picks base clock (0) or scaled clock (1).
// - Joined pair enable is the odd bit; even output stays disabled.
// - In run mode prescaler stops when all eight enables are zero.
package ppac_pkg;
  localparam logic [7:0] IDX_CH_ENABLE = 8'h00;
  localparam logic [7:0] IDX_POLARITY = 8'h01;
  localparam logic [7:0] IDX_CLK_SEL = 8'h02;
  localparam logic [7:0] IDX_PRESCALE = 8'h03;
  localparam logic [7:0] IDX_ALIGN = 8'h04;
  localparam logic [7:0] IDX_CTRL = 8'h05;
  // One byte register per word, so the byte address is four times the index
  localparam logic [7:0] ADDR_PRESCALE = {IDX_PRESCALE[5:0], 2'b00};
  localparam logic [7:0] ADDR_ALIGN = {IDX_ALIGN[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_CH_ENABLE = {IDX_CH_ENABLE[5:0], 2'b00};
  localparam logic [7:0] ADDR_CLK_SEL = {IDX_CLK_SEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_POLARITY = {IDX_POLARITY[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam int CLKB_LSB = 4;
  localparam int CLKA_LSB = 0;
  localparam int JOIN_LSB = 4;
  localparam int STOP_WAIT_BIT = 3;
  localparam int STOP_FREEZE_BIT = 2;
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam logic [7:0] CTRL_MASK = 8'hfc;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int PRESC_W = 7;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] align;
    logic [7:0] ctrl;
    logic [7:0] enable;
    logic [7:0] clk_sel;
    logic [7:0] polarity;
  } ppac_regs_t;

  // Effective per-channel settings handed to the channel counters
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] center;
    logic [7:0] polarity;
    logic [7:0] scaled_sel;
    logic [7:0] out_mask;
    logic [3:0] joined;
  } ppac_chan_cfg_t;
endpackage

// ---- design/ppac_prescaler.sv ----
// Power-of-two prescaler producing clock A and clock B enable pulses
`timescale 1ns/1ps
module ppac_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [2:0] clk_a_divider_code,
  input wire logic [2:0] clk_b_divider_code,
  output logic clk_a_tick,
  output logic clk_b_tick
);
  logic [ppac_pkg::PRESC_W-1:0] cnt_r;
  logic [ppac_pkg::PRESC_W-1:0] cnt_nxt;
  logic a_nxt;
  logic b_nxt;

  // Tick when the low n bits are all ones; code 0 ticks each cycle
  function automatic logic tap(input logic [6:0] c, input logic [2:0] n);
    logic [6:0] m;
    m = 7'(({7'h00, 1'b1} << n) - 8'h01);
    tap = ((c & m) == m);
  endfunction

  always_comb begin
    cnt_nxt = cnt_r;
    a_nxt = 1'b0;
    b_nxt = 1'b0;
    if (run) begin
      cnt_nxt = cnt_r + 7'h01;
      a_nxt = tap(cnt_r, clk_a_divider_code);
      b_nxt = tap(cnt_r, clk_b_divider_code);
    end
  end

  // Held count resumes where it stopped after a gate lifts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= ppac_pkg::PRESC_RESET;
      clk_a_tick <= 1'b0;
      clk_b_tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_a_tick <= a_nxt;
      clk_b_tick <= b_nxt;
    end
  end
endmodule

// ---- design/ppac_chan_map.sv ----
// Per-channel mapping of alignment, join and clock settings
`timescale 1ns/1ps
module ppac_chan_map (
  input wire ppac_pkg::ppac_regs_t regs,
  output ppac_pkg::ppac_chan_cfg_t cfg
);
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pair
      logic join_bit;
      assign join_bit = regs.ctrl[ppac_pkg::JOIN_LSB + p];
      assign cfg.joined[p] = join_bit;
      // Odd channel settings govern a joined pair
      assign cfg.enable[2*p+1] = regs.enable[2*p+1];
      assign cfg.enable[2*p] = regs.enable[2*p] & ~join_bit;
      assign cfg.center[2*p+1] = regs.align[2*p+1];
      assign cfg.center[2*p] = join_bit ? regs.align[2*p+1]
                                        : regs.align[2*p];
      assign cfg.polarity[2*p+1] = regs.polarity[2*p+1];
      assign cfg.polarity[2*p] = join_bit ? regs.polarity[2*p+1]
                                          : regs.polarity[2*p];
      assign cfg.scaled_sel[2*p+1] = regs.clk_sel[2*p+1];
      assign cfg.scaled_sel[2*p] = join_bit ? regs.clk_sel[2*p+1]
                                            : regs.clk_sel[2*p];
      assign cfg.out_mask[2*p+1] = 1'b1;
      assign cfg.out_mask[2*p] = ~join_bit;
    end
  endgenerate
endmodule

// ---- design/ppac_ctrl.sv ----
// AHB-Lite control block of the eight-channel modulator
`timescale 1ns/1ps
module ppac_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wait_mode,
  input wire logic freeze_mode,
  output logic clk_a_tick,
  output logic clk_b_tick,
  output logic scaled_clock_a_sel_dummy,
  output ppac_pkg::ppac_chan_cfg_t chan_cfg,
  output logic [2:0] clk_a_divider_code,
  output logic [2:0] clk_b_divider_code
);
  ppac_pkg::ppac_regs_t regs_r;
  ppac_pkg::ppac_regs_t regs_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic gate_wait;
  logic gate_freeze;
  logic all_off;
  logic presc_run;
  logic a_tick;
  logic b_tick;
  logic access;

  // Read mux; unmapped offsets read as zero
  function automatic logic [7:0] rd_byte(input ppac_pkg::ppac_regs_t r,
                                         input logic [7:0] a,
                                         input logic [2:0] st);
    case (a)
      ppac_pkg::ADDR_PRESCALE: rd_byte = r.prescale;
      ppac_pkg::ADDR_ALIGN: rd_byte = r.align;
      ppac_pkg::ADDR_CTRL: rd_byte = r.ctrl;
      ppac_pkg::ADDR_CH_ENABLE: rd_byte = r.enable;
      ppac_pkg::ADDR_CLK_SEL: rd_byte = r.clk_sel;
      ppac_pkg::ADDR_POLARITY: rd_byte = r.polarity;
      ppac_pkg::ADDR_STATUS: rd_byte = {5'h00, st};
      default: rd_byte = 8'h00;
    endcase
  endfunction

  assign access = hsel & hready &
                  (htrans == ppac_pkg::HTRANS_NONSEQ ||
                   htrans == ppac_pkg::HTRANS_SEQ);

  // Gating never touches the bus path, so registers stay reachable
  assign gate_wait = wait_mode & regs_r.ctrl[ppac_pkg::STOP_WAIT_BIT];
  assign gate_freeze = freeze_mode &
                       regs_r.ctrl[ppac_pkg::STOP_FREEZE_BIT];
  // Effective enables: an even bit of a joined pair counts for nothing
  assign all_off = (chan_cfg.enable == 8'h00);
  assign presc_run = ~gate_wait & ~gate_freeze & ~all_off;

  always_comb begin
    regs_nxt = regs_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        ppac_pkg::ADDR_PRESCALE:
          regs_nxt.prescale = hwdata[7:0] & ppac_pkg::PRESCALE_MASK;
        ppac_pkg::ADDR_ALIGN: regs_nxt.align = hwdata[7:0];
        ppac_pkg::ADDR_CTRL: regs_nxt.ctrl = hwdata[7:0] & ppac_pkg::CTRL_MASK;
        ppac_pkg::ADDR_CH_ENABLE: regs_nxt.enable = hwdata[7:0];
        ppac_pkg::ADDR_CLK_SEL: regs_nxt.clk_sel = hwdata[7:0];
        ppac_pkg::ADDR_POLARITY: regs_nxt.polarity = hwdata[7:0];
        default: regs_nxt = regs_r;
      endcase
    end
    if (access) begin
      if (hwrite) begin
        wr_pend_nxt = 1'b1;
        wr_addr_nxt = {haddr[7:2], 2'b00};
      end else begin
        // Next state, so a read right behind a write sees the new byte
        rdata_nxt = {24'h000000, rd_byte(regs_nxt, {haddr[7:2], 2'b00},
                     {presc_run, gate_freeze, gate_wait})};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs_r <= '0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end else begin
      regs_r <= regs_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Zero wait states; always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  assign clk_a_divider_code = regs_r.prescale[ppac_pkg::CLKA_LSB +: 3];
  assign clk_b_divider_code = regs_r.prescale[ppac_pkg::CLKB_LSB +: 3];

  ppac_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(presc_run),
    .clk_a_divider_code(clk_a_divider_code),
    .clk_b_divider_code(clk_b_divider_code),
    .clk_a_tick(a_tick),
    .clk_b_tick(b_tick)
  );
  assign clk_a_tick = a_tick;
  assign clk_b_tick = b_tick;
  assign scaled_clock_a_sel_dummy = 1'b0;

  // Even channel holds the high byte when joined; counters live downstream
  ppac_chan_map u_map (
    .regs(regs_r),
    .cfg(chan_cfg)
  );
endmodule

// ---- tb/ppac_ctrl_checker.sv ----
// Port checker of the modulator control block
`timescale 1ns/1ps
module ppac_ctrl_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic clk_a_tick,
  input wire logic clk_b_tick,
  input wire ppac_pkg::ppac_chan_cfg_t chan_cfg,
  input wire logic [2:0] clk_a_divider_code,
  input wire logic [2:0] clk_b_divider_code
);
  logic pend_r, wr_r;
  logic [7:0] addr_r;
  logic [3:0] j;
  assign j = chan_cfg.joined;
  // Data phase tracking, since the checker cannot see the register file
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {pend_r, wr_r, addr_r} <= '0;
    else {pend_r, wr_r, addr_r} <= {hsel & hready & htrans[1], hwrite, haddr};
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_of(logic [7:0] a);
    pend_r && !wr_r && addr_r == a;
  endsequence
  sequence wr_of(logic [7:0] a);
    pend_r && wr_r && addr_r == a;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_code_a: assert property (wr_of(ppac_pkg::ADDR_PRESCALE) |=>
    clk_a_divider_code == $past(hwdata[2:0])) else $error("code A not taken");
  a_code_b: assert property (wr_of(ppac_pkg::ADDR_PRESCALE) |=>
    clk_b_divider_code == $past(hwdata[6:4])) else $error("code B not taken");
  a_rd_presc: assert property (rd_of(ppac_pkg::ADDR_PRESCALE) |->
    hrdata[7:0] == {1'h0, clk_b_divider_code, 1'h0, clk_a_divider_code})
    else $error("prescale readback wrong");
  a_rd_ctrl: assert property (rd_of(ppac_pkg::ADDR_CTRL) |->
    hrdata[1:0] == 2'h0 && hrdata[7:4] == j) else $error("ctrl readback");
  a_gap_a: assert property (clk_a_tick && clk_a_divider_code != 3'h0 &&
    $stable(clk_a_divider_code) |=> !clk_a_tick) else $error("A tick early");
  a_gap_b: assert property (clk_b_tick && clk_b_divider_code != 3'h0 &&
    $stable(clk_b_divider_code) |=> !clk_b_tick) else $error("B tick early");
  a_idle_stop: assert property ((chan_cfg.enable == 8'h00) [*2] |->
    !clk_a_tick && !clk_b_tick) else $error("ticks with no channel on");
  a_out_mask: assert property (chan_cfg.out_mask ==
    ~{1'h0, j[3], 1'h0, j[2], 1'h0, j[1], 1'h0, j[0]})
    else $error("joined even output not masked");
  a_join_even: assert property (
    (chan_cfg.enable & {1'h0, j[3], 1'h0, j[2], 1'h0, j[1], 1'h0, j[0]})
    == 8'h00) else $error("even channel of a pair enabled");
endmodule
bind ppac_ctrl ppac_ctrl_checker u_chk (.*);

// ---- tb/tb.sv ----
// Self-checking bench of the modulator control block
`timescale 1ns/1ps
module tb;
  typedef struct packed { logic [7:0] a, d, e; } ppac_row_t;
  typedef struct packed { logic [7:0] c; logic w, f, e, r; } ppac_gate_t;
  ppac_row_t rows [6] = '{24'h0cff77, 24'h10a5a5, 24'h140f0c, 24'h085a5a,
                          24'h046969, 24'h3cff00};
  ppac_gate_t gates [6] = '{12'h08a, 12'h00b, 12'h046, 12'h007, 12'h0c3,
                            12'h000};
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic wait_mode = 1'h0, freeze_mode = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hready, hreadyout, hresp, clk_a_tick, clk_b_tick;
  logic [2:0] clk_a_divider_code, clk_b_divider_code;
  ppac_pkg::ppac_chan_cfg_t chan_cfg;
  int num_errors = 0, tests_run = 0;
  assign hready = hreadyout;
  initial forever #4 hclk = ~hclk;
  ppac_ctrl dut (.*, .hsize(3'h2), .scaled_clock_a_sel_dummy());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hready === 1'h1) break;
    end
    if (n == 50) begin
      num_errors++;
      final_report;
    end
  endtask
  // One transfer, address phase then data phase, no pipelining
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= ppac_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // Any window of 256 cycles holds exactly 256 >> n ticks
  task automatic cnt(input logic b, input int lim, output int c);
    repeat (3) @(posedge hclk);
    c = 0;
    repeat (lim) begin
      @(negedge hclk);
      c += int'((b ? clk_b_tick : clk_a_tick) === 1'h1);
    end
    @(posedge hclk);
  endtask
  // Joined view of a per-channel byte: the even bit follows the odd one
  function automatic logic [7:0] odd_rules(input logic [7:0] r, input int p);
    odd_rules = r;
    odd_rules[2 * p] = r[2 * p + 1];
  endfunction
  initial begin
    int c;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdchk(ppac_pkg::ADDR_PRESCALE, ppac_pkg::REG_RESET);
    rdchk(ppac_pkg::ADDR_CTRL, ppac_pkg::REG_RESET);
    freeze_mode <= 1'h1;
    // Every channel is still off, so alignment may change here
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk(32'(chan_cfg.center), 32'h0a5);
    chk(32'(chan_cfg.scaled_sel), 32'h05a);
    chk(32'(chan_cfg.polarity), 32'h069);
    freeze_mode <= 1'h0;
    wr(ppac_pkg::ADDR_CH_ENABLE, 8'h01);
    for (int n = 0; n < 8; n++) begin
      wr(ppac_pkg::ADDR_PRESCALE, 8'(((7 - n) << 4) | n));
      cnt(1'h0, 256, c);
      chk(32'(c), 32'(256 >> n));
      cnt(1'h1, 256, c);
      chk(32'(c), 32'(256 >> (7 - n)));
    end
    wr(ppac_pkg::ADDR_PRESCALE, 8'h00);
    foreach (gates[i]) begin
      wr(ppac_pkg::ADDR_CTRL, gates[i].c);
      wr(ppac_pkg::ADDR_CH_ENABLE, {7'h0, gates[i].e});
      wait_mode <= gates[i].w;
      freeze_mode <= gates[i].f;
      cnt(1'h0, 16, c);
      chk(32'(c), gates[i].r ? 32'h10 : 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      // Join bits only move while the pair is off
      wr(ppac_pkg::ADDR_CH_ENABLE, 8'h00);
      wr(ppac_pkg::ADDR_CTRL, 8'(8'h10 << i));
      wr(ppac_pkg::ADDR_CH_ENABLE, 8'hff);
      @(posedge hclk);
      chk(32'(chan_cfg.joined), 32'(4'h1 << i));
      chk({24'h0, chan_cfg.enable}, {24'h0, ~(8'h01 << 2 * i)});
      chk({24'h0, chan_cfg.out_mask}, {24'h0, ~(8'h01 << 2 * i)});
      chk({24'h0, chan_cfg.center}, {24'h0, odd_rules(8'ha5, i)});
      chk({24'h0, chan_cfg.polarity}, {24'h0, odd_rules(8'h69, i)});
      chk({24'h0, chan_cfg.scaled_sel}, {24'h0, odd_rules(8'h5a, i)});
    end
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdchk(ppac_pkg::ADDR_ALIGN, ppac_pkg::REG_RESET);
    rdchk(ppac_pkg::ADDR_CTRL, ppac_pkg::REG_RESET);
    final_report;
  end
endmodule
